/* File: hdl/systk_pkg.sv */
// Package of the system tick timer: register map, field positions and
// reset values, plus the request and answer carriers of the register port.
// Assumes a single-clock core side that issues one register access a cycle.
`default_nettype none

package systk_pkg;

  // ==========================================================================
  // Register map
  localparam logic [31:0] SYSTK_BASE_ADDR  = 32'he000_e000;
  localparam logic [31:0] SYSTK_OFF_CTRL   = 32'h0000_0010;
  localparam logic [31:0] SYSTK_OFF_RELOAD = 32'h0000_0014;
  localparam logic [31:0] SYSTK_OFF_CURR   = 32'h0000_0018;

  // ==========================================================================
  // Field positions and widths
  localparam int          SYSTK_CNT_W      = 24;
  localparam int          SYSTK_EN_BIT     = 0;
  localparam int          SYSTK_INT_BIT    = 1;
  localparam int          SYSTK_SRC_BIT    = 2;
  localparam int          SYSTK_FLAG_BIT   = 16;

  // ==========================================================================
  // Reset values
  localparam logic [31:0] SYSTK_CTRL_RST   = 32'h0000_0000;
  localparam logic [23:0] SYSTK_RELOAD_RST = 24'h00_0000;
  localparam logic [23:0] SYSTK_CURR_RST   = 24'h00_0000;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [31:0] addr;
    logic [31:0] wdata;
  } systk_req_t;

  typedef struct packed {
    logic        valid;
    logic        err;
    logic [31:0] rdata;
  } systk_rsp_t;

endpackage : systk_pkg

`default_nettype wire

/* File: hdl/systk_timer.sv */
// System tick down counter with its three memory-mapped registers.
// Assumes the core presents at most one access per cycle on req_in and that
// the reference clock is slow enough to be sampled by mclk_in.
//
// Overview of operation
// - 24-bit down counter wrapping to reload value
// - Count to zero, reload next tick, continue
// - Flag bit 16 set on step 1 to 0
// - Flag cleared by status read or current write
// - Zero reload keeps counter parked at zero
// - Any current value write zeroes the counter
// - Bit 2 selects core or reference clock
// - Bit 1 pends exception on count to zero
// - Bit 0 runs counter continuously, clear stops
// - Reload holds 24 bits, upper bits reserved
// - Current read returns live value, upper zero
// - Registers at base plus 0x10, 0x14, 0x18
`default_nettype none

module systk_timer #(
  parameter int CNT_W = systk_pkg::SYSTK_CNT_W
) (
  // Clock and reset
  input  wire                  mclk_in,
  input  wire                  reset_n_in,
  // Register port
  input  wire systk_pkg::systk_req_t req_in,
  output var  systk_pkg::systk_rsp_t rsp_out,
  // Reference clock from outside the core domain
  input  wire                  ref_clk_in,
  // Exception request
  output logic                 tick_pend_out
);
  import systk_pkg::*;

  // ==========================================================================
  // Elaboration check
  generate
    if (CNT_W < 2 || CNT_W > SYSTK_CNT_W) begin : g_bad_width
      $error("systk_timer: CNT_W out of range");
    end
  endgenerate

  // ==========================================================================
  // Address decode
  function automatic logic addr_hit(input logic [31:0] addr, input logic [31:0] off);
    addr_hit = (addr == (SYSTK_BASE_ADDR + off));
  endfunction

  logic [CNT_W-1:0] curr_r;
  logic [CNT_W-1:0] reload_r;
  logic             enable_r;
  logic             zero_exception_enable_r;
  logic             clock_select_bit_r;
  logic             zero_reached_flag_r;
  logic [2:0]       ref_sync_r;
  systk_rsp_t       rsp_r;
  logic             pend_r;

  wire hit_ctrl   = addr_hit(req_in.addr, SYSTK_OFF_CTRL);
  wire hit_reload = addr_hit(req_in.addr, SYSTK_OFF_RELOAD);
  wire hit_curr   = addr_hit(req_in.addr, SYSTK_OFF_CURR);
  wire hit_any    = hit_ctrl | hit_reload | hit_curr;
  wire acc        = req_in.rd | req_in.wr;
  wire ctrl_rd    = req_in.rd & hit_ctrl;
  wire ctrl_wr    = req_in.wr & hit_ctrl;
  wire reload_wr  = req_in.wr & hit_reload;
  wire curr_wr    = req_in.wr & hit_curr;

  // ==========================================================================
  // Count source
  wire ref_edge   = ref_sync_r[1] & ~ref_sync_r[2];
  wire step       = enable_r & (clock_select_bit_r | ref_edge);
  wire curr_zero  = (curr_r == '0);
  wire curr_one   = (curr_r == CNT_W'(1));
  wire hit_zero   = step & curr_one;

  // ==========================================================================
  // Next values
  wire [CNT_W-1:0] curr_nxt =
    curr_wr   ? '0 :
    !step     ? curr_r :
    curr_zero ? reload_r :
                curr_r - CNT_W'(1);

  // Set wins over either clear
  wire flag_nxt = hit_zero | (zero_reached_flag_r & ~ctrl_rd & ~curr_wr);

  wire [31:0] ctrl_view = {15'h0000, zero_reached_flag_r, 13'h0000,
                           clock_select_bit_r, zero_exception_enable_r, enable_r};
  wire [31:0] rd_mux =
    hit_ctrl   ? ctrl_view :
    hit_reload ? {{(32-CNT_W){1'b0}}, reload_r} :
    hit_curr   ? {{(32-CNT_W){1'b0}}, curr_r} :
                 32'h0000_0000;

  wire systk_rsp_t rsp_nxt = '{valid: acc, err: acc & ~hit_any,
                                rdata: (req_in.rd & hit_any) ? rd_mux : 32'h0000_0000};

  // ==========================================================================
  // Reference clock synchroniser
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ref_sync_r <= 3'h0;
    end else begin
      ref_sync_r <= {ref_sync_r[1:0], ref_clk_in};
    end
  end

  // ==========================================================================
  // Control register
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      enable_r                <= SYSTK_CTRL_RST[SYSTK_EN_BIT];
      zero_exception_enable_r <= SYSTK_CTRL_RST[SYSTK_INT_BIT];
      clock_select_bit_r      <= SYSTK_CTRL_RST[SYSTK_SRC_BIT];
    end else if (ctrl_wr) begin
      enable_r                <= req_in.wdata[SYSTK_EN_BIT];
      zero_exception_enable_r <= req_in.wdata[SYSTK_INT_BIT];
      clock_select_bit_r      <= req_in.wdata[SYSTK_SRC_BIT];
    end
  end

  // ==========================================================================
  // Reload register
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reload_r <= SYSTK_RELOAD_RST[CNT_W-1:0];
    end else if (reload_wr) begin
      reload_r <= req_in.wdata[CNT_W-1:0];
    end
  end

  // ==========================================================================
  // Counter, flag, exception and answer
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      curr_r              <= SYSTK_CURR_RST[CNT_W-1:0];
      zero_reached_flag_r <= SYSTK_CTRL_RST[SYSTK_FLAG_BIT];
      pend_r              <= 1'b0;
      rsp_r               <= '0;
    end else begin
      curr_r              <= curr_nxt;
      zero_reached_flag_r <= flag_nxt;
      pend_r              <= hit_zero & zero_exception_enable_r;
      rsp_r               <= rsp_nxt;
    end
  end

  assign rsp_out       = rsp_r;
  assign tick_pend_out = pend_r;

  // ==========================================================================
  // Assertions
  property p_decrement;
    @(posedge mclk_in) disable iff (!reset_n_in)
    (step && !curr_zero && !curr_wr) |=> (curr_r == $past(curr_r) - CNT_W'(1));
  endproperty
  a_decrement: assert property (p_decrement) else $error("counter did not decrement");

  property p_wrap;
    @(posedge mclk_in) disable iff (!reset_n_in)
    (step && curr_zero && !curr_wr) |=> (curr_r == $past(reload_r));
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not reload at zero");

  property p_flag_set;
    @(posedge mclk_in) disable iff (!reset_n_in)
    hit_zero |=> zero_reached_flag_r ##1 (zero_reached_flag_r || $past(ctrl_rd || curr_wr));
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set on step to zero");

  property p_flag_clear;
    @(posedge mclk_in) disable iff (!reset_n_in)
    ((ctrl_rd || curr_wr) && !hit_zero) |=> !zero_reached_flag_r;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

  property p_park_zero;
    @(posedge mclk_in) disable iff (!reset_n_in)
    (curr_zero && reload_r == '0 && !reload_wr) [*2] |-> ##1 curr_zero;
  endproperty
  a_park_zero: assert property (p_park_zero) else $error("counter left zero with zero reload");

  property p_write_clears;
    @(posedge mclk_in) disable iff (!reset_n_in)
    curr_wr |=> (curr_zero && !tick_pend_out) or ($past(hit_zero) && curr_zero);
  endproperty
  a_write_clears: assert property (p_write_clears) else $error("current write did not zero counter");

  property p_source;
    @(posedge mclk_in) disable iff (!reset_n_in)
    (!clock_select_bit_r && !ref_edge && !curr_wr) |=> $stable(curr_r);
  endproperty
  a_source: assert property (p_source) else $error("count moved without reference edge");

  property p_pend;
    @(posedge mclk_in) disable iff (!reset_n_in)
    tick_pend_out |-> $past(hit_zero && zero_exception_enable_r);
  endproperty
  a_pend: assert property (p_pend) else $error("exception pended without cause");

  property p_pend_cause;
    @(posedge mclk_in) disable iff (!reset_n_in)
    (hit_zero && zero_exception_enable_r) |=> tick_pend_out;
  endproperty
  a_pend_cause: assert property (p_pend_cause) else $error("exception not pended");

  property p_stopped;
    @(posedge mclk_in) disable iff (!reset_n_in)
    (!enable_r && !curr_wr) |=> $stable(curr_r);
  endproperty
  a_stopped: assert property (p_stopped) else $error("disabled counter moved");

  property p_curr_read;
    @(posedge mclk_in) disable iff (!reset_n_in)
    (req_in.rd && hit_curr) |=> (rsp_out.valid && rsp_out.rdata == {{(32-CNT_W){1'b0}}, $past(curr_r)});
  endproperty
  a_curr_read: assert property (p_curr_read) else $error("current read value wrong");

  property p_ctrl_reserved;
    @(posedge mclk_in) disable iff (!reset_n_in)
    (req_in.rd && hit_ctrl) |=> (rsp_out.rdata[31:17] == 15'h0000 && rsp_out.rdata[15:3] == 13'h0000);
  endproperty
  a_ctrl_reserved: assert property (p_ctrl_reserved) else $error("reserved status bits not zero");

  c_wrap:     cover property (@(posedge mclk_in) disable iff (!reset_n_in) step && curr_zero && reload_r != '0);
  c_pend:     cover property (@(posedge mclk_in) disable iff (!reset_n_in) tick_pend_out);
  c_ref_step: cover property (@(posedge mclk_in) disable iff (!reset_n_in) step && !clock_select_bit_r);
  c_flag_rd:  cover property (@(posedge mclk_in) disable iff (!reset_n_in) ctrl_rd && zero_reached_flag_r);

endmodule // systk_timer

`default_nettype wire

/* File: test/tb_top.sv */
// Self-checking bench for the system tick timer: register reads and writes
// through the native request/answer port, counting on core and reference clock.
// Assumes the answer is registered on the taking edge and held one cycle, as handed over.
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import systk_pkg::*;

  // ==========================================================================
  // Signals
  logic        mclk_in;
  logic        reset_n_in;
  logic        ref_clk_in;
  systk_req_t  req_in;
  systk_rsp_t  rsp_out;
  logic        tick_pend_out;
  int          n_mismatch = 0;
  int          compares   = 0;
  int          n_pend     = 0;
  int          base_pend;

  systk_timer i_dut (
    .mclk_in       (mclk_in),
    .reset_n_in    (reset_n_in),
    .req_in        (req_in),
    .rsp_out       (rsp_out),
    .ref_clk_in    (ref_clk_in),
    .tick_pend_out (tick_pend_out)
  );

  // ==========================================================================
  // Clock and pend pulse counter
  initial begin
    mclk_in = 1'b0;
    forever #2 mclk_in = ~mclk_in;
  end

  always @(posedge mclk_in) begin
    if (tick_pend_out === 1'b1) n_pend <= n_pend + 1;
  end

  // ==========================================================================
  // Tasks
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic acc(input logic wr, input logic [31:0] off, input logic [31:0] wd,
                     input logic err, input logic [31:0] exp);
    req_in.rd    = ~wr;
    req_in.wr    = wr;
    req_in.addr  = SYSTK_BASE_ADDR + off;
    req_in.wdata = wd;
    @(posedge mclk_in);
    @(negedge mclk_in);
    check_word({31'h0, rsp_out.valid}, 32'h1, "answer valid");
    check_word({31'h0, rsp_out.err}, {31'h0, err}, "answer error");
    check_word(rsp_out.rdata, exp, "read data");
    req_in = '0;
    @(negedge mclk_in);
    check_word({31'h0, rsp_out.valid}, 32'h0, "answer drop");
  endtask

  task automatic rd(input logic [31:0] off, input logic [31:0] exp);
    acc(1'b0, off, 32'h0, 1'b0, exp);
  endtask

  task automatic wrt(input logic [31:0] off, input logic [31:0] wd);
    acc(1'b1, off, wd, 1'b0, 32'h0);
  endtask

  task automatic ref_edges(input int n);
    repeat (n) begin
      ref_clk_in = 1'b1;
      repeat (4) @(negedge mclk_in);
      ref_clk_in = 1'b0;
      repeat (4) @(negedge mclk_in);
    end
  endtask

  // ==========================================================================
  // Watchdog
  initial begin
    #8000;
    n_mismatch++;
    $display("[ERR] %0t watchdog expired", $time);
    report_and_stop;
  end

  // ==========================================================================
  // Main sequence
  initial begin
    req_in     = '0;
    ref_clk_in = 1'b0;
    reset_n_in = 1'b0;
    repeat (3) @(negedge mclk_in);
    reset_n_in = 1'b1;
    @(negedge mclk_in);
    rd(SYSTK_OFF_CTRL, 32'h0000_0000);
    rd(SYSTK_OFF_RELOAD, 32'h0000_0000);
    rd(SYSTK_OFF_CURR, 32'h0000_0000);
    acc(1'b0, 32'h0000_001c, 32'h0, 1'b1, 32'h0);
    acc(1'b1, 32'h0000_0020, 32'h5, 1'b1, 32'h0);
    wrt(SYSTK_OFF_RELOAD, 32'hffff_ffff);
    rd(SYSTK_OFF_RELOAD, 32'h00ff_ffff);
    wrt(SYSTK_OFF_CTRL, 32'hffff_fff8);
    rd(SYSTK_OFF_CTRL, 32'h0000_0000);
    // Core clock, reload 5: six cycles a period
    wrt(SYSTK_OFF_RELOAD, 32'h0000_0005);
    wrt(SYSTK_OFF_CURR, 32'h0000_1234);
    rd(SYSTK_OFF_CURR, 32'h0000_0000);
    base_pend = n_pend;
    wrt(SYSTK_OFF_CTRL, 32'h0000_0007);
    repeat (19) @(negedge mclk_in);
    wrt(SYSTK_OFF_CTRL, 32'h0000_0006);
    rd(SYSTK_OFF_CTRL, 32'h0001_0006);
    rd(SYSTK_OFF_CTRL, 32'h0000_0006);
    rd(SYSTK_OFF_CURR, 32'h0000_0003);
    repeat (5) @(negedge mclk_in);
    rd(SYSTK_OFF_CURR, 32'h0000_0003);
    check_word(n_pend - base_pend, 32'h3, "pend count");
    // Reference clock, reload 2, exception off
    wrt(SYSTK_OFF_RELOAD, 32'h0000_0002);
    wrt(SYSTK_OFF_CURR, 32'h0000_0000);
    wrt(SYSTK_OFF_CTRL, 32'h0000_0001);
    base_pend = n_pend;
    repeat (6) @(negedge mclk_in);
    rd(SYSTK_OFF_CURR, 32'h0000_0000);
    ref_edges(4);
    rd(SYSTK_OFF_CURR, 32'h0000_0002);
    check_word(n_pend - base_pend, 32'h0, "pend count");
    wrt(SYSTK_OFF_CURR, 32'h0000_0007);
    rd(SYSTK_OFF_CTRL, 32'h0000_0001);
    rd(SYSTK_OFF_CURR, 32'h0000_0000);
    // Zero reload parks the counter
    wrt(SYSTK_OFF_RELOAD, 32'h0000_0000);
    wrt(SYSTK_OFF_CTRL, 32'h0000_0005);
    repeat (10) @(negedge mclk_in);
    rd(SYSTK_OFF_CURR, 32'h0000_0000);
    rd(SYSTK_OFF_CTRL, 32'h0000_0005);
    // Current write with exception enabled must not pend
    base_pend = n_pend;
    wrt(SYSTK_OFF_CTRL, 32'h0000_0007);
    wrt(SYSTK_OFF_CURR, 32'h0000_0009);
    repeat (2) @(negedge mclk_in);
    check_word(n_pend - base_pend, 32'h0, "write pend");
    rd(SYSTK_OFF_CURR, 32'h0000_0000);
    report_and_stop;
  end
endmodule // tb_top

`default_nettype wire
